// *** design/spi_status_lock_consts.vh ***
// Named constants for the serial slave front end with status byte and write lock.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef SPI_STATUS_LOCK_CONSTS_VH
`define SPI_STATUS_LOCK_CONSTS_VH

// Frame geometry
`define FRAME_BITS        5'h10
`define CMD_BITS          5'h08
`define BIT_CNT_RESET     5'h00
`define OUT_IDX_TOP       4'hf
// Synchroniser reset levels, one bit per pin: readback, data in, clock, select
// The clock idles low; resetting its stages high would fake a clock fall after reset
`define SYNC_IDLE_LEVEL   4'hd

// Status flag byte layout
`define STAT_FIXED        4'ha
`define STAT_ZERO_BIT     1'b0

// Command codes without parity
`define CMD_WRITE_LOCK    7'h5e
`define CMD_WRITE_UNLOCK  7'h5d
`define CMD_CONFIG_ONE    7'h5b
`define CMD_CONFIG_TWO    7'h4a
`define CMD_STANDBY       7'h3e

// Data values that qualify special commands
`define DATA_LOCK         8'haa
`define DATA_UNLOCK       8'h55
`define DATA_STANDBY      8'h00

// Reset values
`define BYTE_ZERO         8'h00
`define CMD_ZERO          7'h00
`define WORD_ZERO         16'h0000

`endif

// *** design/pin_sync.v ***
// Two-stage synchroniser for a group of pin inputs, one generate entry per bit.
// Assumes the pins are asynchronous to clk; only the second stage is read outside.
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter WIDTH = 4,
	parameter [WIDTH-1:0] RESET_LEVEL = {WIDTH{1'b1}}
) (
	// Clock and reset
	input  wire             clk,
	input  wire             srst,
	// Pins and synchronised levels
	input  wire [WIDTH-1:0] pin,
	output wire [WIDTH-1:0] level
);

	genvar i;

	// Each bit gets its own pair of flops so no stage feeds logic early
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg first;
			reg second;
			always @(posedge clk) begin
				if (srst) begin
					first  <= RESET_LEVEL[i];
					second <= RESET_LEVEL[i];
				end else begin
					first  <= pin[i];
					second <= first;
				end
			end
			assign level[i] = second;
		end
	endgenerate

endmodule // pin_sync

`default_nettype wire

// *** design/spi_status_lock.v ***
// Serial slave front end: 16-bit frames, status flag byte, register data byte,
// software write lock and diagnostic-state write protection.
// Assumes the serial pins are asynchronous and much slower than clk (clock period
// well above 8 clk cycles), and an outside decoder answers cmd_code in one cycle.
`timescale 1ns/1ns
`default_nettype none
`include "spi_status_lock_consts.vh"

// Summary of operation
// - Status byte upper nibble shifts out as 1,0,1,0 during the command byte.
// - Status bit 3 reports that the previous frame was a write access.
// - Status bit 2 reports an output data error in the previous frame.
// - Status bits describe the previous frame or earlier ones, never the current one.
// - Error bits from a truncated frame persist until a later read access clears them.
// - Clock fall while deselected with output high sets output error for the next frame.
// - An output error never rejects the frame; the command still executes.
// - Second byte returns the addressed register, unused bits zero.
// - Bits sampled on clock fall, launched on clock rise, 16 per frame.
// - Lock command with data AAh blocks writes to lock-protected registers.
// - Unlock command with data 55h re-enables writes to protected registers.
// - Configuration writes need the diagnostic state and are also lock-protected.
// - Standby write honoured only with data 00h and ignores the lock.
// - Power-on reset events reload all initial values except the pin synchroniser stages.
// - Self-test completion re-initialises the listed registers; state code refreshes.
// - 16 bits MSB first; deselect holds the transmit path in reset, output released.
// - First byte holds 7-bit command above a parity bit.
// - Command byte is checked for even parity.
module spi_status_lock (
	// Clock and reset
	input  wire       clk,
	input  wire       srst,
	// Serial pins
	input  wire       chip_select_n,
	input  wire       serial_clock_pin,
	input  wire       serial_data_in,
	input  wire       serial_data_readback,
	output reg        serial_data_out,
	output reg        serial_data_oe,
	// Device state and events
	input  wire       diag_state,
	input  wire       self_test_done,
	input  wire       power_on_reset_event,
	// Command decoder answers, valid the cycle after cmd_code changes
	input  wire       cmd_is_write,
	input  wire       cmd_undefined,
	input  wire       cmd_lock_protected,
	input  wire [7:0] read_data,
	// Register file requests
	output reg  [6:0] cmd_code,
	output reg        read_strobe,
	output reg        write_strobe,
	output reg  [7:0] write_data,
	output reg        standby_request,
	output reg        reinit_strobe,
	output reg        state_code_refresh,
	output reg        write_locked
);

	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_SHIFT = 3'b010;
	localparam [2:0] ST_EXEC  = 3'b100;

	wire [3:0] sync_level;
	wire       cs_n_s;
	wire       sclk_s;
	wire       sdi_s;
	wire       rdbk_s;

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg         sclk_d;
	reg         cs_n_d;
	reg  [4:0]  bit_cnt;
	reg  [3:0]  out_idx;
	reg  [15:0] rx_word;
	reg  [15:0] tx_word;
	reg         fetch_pending;
	reg         frame_sdo_err;
	reg         idle_sdo_err;
	reg         flag_write;
	reg         flag_sdo_err;
	reg         flag_frame_err;
	reg         cmd_was_write;
	reg         cmd_was_undef;
	reg         cmd_was_prot;

	wire sclk_fall;
	wire sclk_rise;
	wire cs_fall;
	wire cs_rise;
	wire full_frame;
	wire parity_ok;
	wire frame_err_now;
	wire frame_valid;
	wire clear_errors;
	wire [7:0] status_byte;
	wire [7:0] data_byte;
	wire write_allowed;

	// All four pins pass two flops before any logic looks at them
	pin_sync #(
		.WIDTH       (4),
		.RESET_LEVEL (`SYNC_IDLE_LEVEL)
	) u_pin_sync (
		.clk   (clk),
		.srst  (srst),
		.pin   ({serial_data_readback, serial_data_in, serial_clock_pin, chip_select_n}),
		.level (sync_level)
	);

	assign cs_n_s = sync_level[0];
	assign sclk_s = sync_level[1];
	assign sdi_s  = sync_level[2];
	assign rdbk_s = sync_level[3];

	// Edge detection on the synchronised levels
	assign sclk_fall = sclk_d & ~sclk_s;
	assign sclk_rise = ~sclk_d & sclk_s;
	assign cs_fall   = cs_n_d & ~cs_n_s;
	assign cs_rise   = ~cs_n_d & cs_n_s;

	// Frame checks evaluated when select rises
	assign full_frame    = (bit_cnt == `FRAME_BITS);
	assign parity_ok     = ~^rx_word[15:8];
	assign frame_err_now = ~full_frame | ~parity_ok | cmd_was_undef;
	assign frame_valid   = ~frame_err_now;
	assign clear_errors  = frame_valid & ~cmd_was_write;

	// Status byte from the flags of the previous frame
	assign status_byte = {`STAT_FIXED, flag_write, flag_sdo_err, `STAT_ZERO_BIT, flag_frame_err};
	assign data_byte   = rx_word[7:0];

	// Configuration writes need diagnostic state; protected writes need the lock open
	assign write_allowed = ~((cmd_was_prot | (cmd_code == `CMD_CONFIG_ONE) | (cmd_code == `CMD_CONFIG_TWO))
		& write_locked)
		& (diag_state | ((cmd_code != `CMD_CONFIG_ONE) & (cmd_code != `CMD_CONFIG_TWO)));

	// Next state: frames open on select fall, execute once on select rise
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (cs_fall) begin
					next_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (cs_rise) begin
					next_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Edge history and state register
	always @(posedge clk) begin
		if (srst | power_on_reset_event) begin
			state  <= ST_IDLE;
			sclk_d <= 1'b0;
			cs_n_d <= 1'b1;
		end else begin
			state  <= next_state;
			sclk_d <= sclk_s;
			cs_n_d <= cs_n_s;
		end
	end

	// Receive path: sample on clock fall, most significant bit first
	// Count and word are kept after select rises, since frame end still needs them
	always @(posedge clk) begin
		if (srst | power_on_reset_event | cs_fall) begin
			bit_cnt <= `BIT_CNT_RESET;
			rx_word <= `WORD_ZERO;
		end else if (sclk_fall && !cs_n_s && bit_cnt != `FRAME_BITS) begin
			rx_word <= {rx_word[14:0], sdi_s};
			bit_cnt <= bit_cnt + 5'h01;
		end
	end

	// Command byte complete: hand the code to the decoder and fetch read data
	always @(posedge clk) begin
		if (srst | power_on_reset_event) begin
			cmd_code      <= `CMD_ZERO;
			read_strobe   <= 1'b0;
			fetch_pending <= 1'b0;
			cmd_was_write <= 1'b0;
			cmd_was_undef <= 1'b0;
			cmd_was_prot  <= 1'b0;
		end else begin
			read_strobe   <= 1'b0;
			fetch_pending <= read_strobe;
			if (cs_fall) begin
				cmd_was_write <= 1'b0;
				cmd_was_undef <= 1'b0;
				cmd_was_prot  <= 1'b0;
			end else if (sclk_fall && !cs_n_s && bit_cnt == (`CMD_BITS - 5'h01)) begin
				cmd_code    <= rx_word[6:0];
				read_strobe <= 1'b1;
			end
			if (read_strobe) begin
				cmd_was_write <= cmd_is_write;
				cmd_was_undef <= cmd_undefined;
				cmd_was_prot  <= cmd_lock_protected;
			end
		end
	end

	// Transmit path: launch on clock rise; released while deselected
	always @(posedge clk) begin
		if (srst | power_on_reset_event | cs_n_s) begin
			serial_data_out <= 1'b1;
			serial_data_oe  <= 1'b0;
			out_idx         <= `OUT_IDX_TOP;
			tx_word         <= `WORD_ZERO;
		end else begin
			serial_data_oe <= 1'b1;
			if (cs_n_d) begin
				tx_word         <= {status_byte, `BYTE_ZERO};
				serial_data_out <= status_byte[7];
				out_idx         <= `OUT_IDX_TOP;
			end else begin
				if (fetch_pending) begin
					tx_word[7:0] <= read_data;
				end
				if (sclk_rise) begin
					serial_data_out <= tx_word[out_idx];
					out_idx         <= out_idx - 4'h1;
				end
			end
		end
	end

	// Output error detection: readback mismatch in frame, stray clock while deselected
	always @(posedge clk) begin
		if (srst | power_on_reset_event) begin
			frame_sdo_err <= 1'b0;
			idle_sdo_err  <= 1'b0;
		end else begin
			if (cs_fall) begin
				frame_sdo_err <= 1'b0;
			end else if (sclk_fall && !cs_n_s && serial_data_oe && rdbk_s != serial_data_out) begin
				frame_sdo_err <= 1'b1;
			end
			// Held until a frame folds it into the flags
			if (sclk_fall && cs_n_s && rdbk_s) begin
				idle_sdo_err <= 1'b1;
			end else if (state == ST_EXEC) begin
				idle_sdo_err <= 1'b0;
			end
		end
	end

	// Status flags updated once per frame; new errors win over a clearing read
	always @(posedge clk) begin
		if (srst | power_on_reset_event) begin
			flag_write     <= 1'b0;
			flag_sdo_err   <= 1'b0;
			flag_frame_err <= 1'b0;
		end else if (state == ST_EXEC) begin
			flag_write     <= full_frame & cmd_was_write;
			flag_sdo_err   <= frame_sdo_err | idle_sdo_err | (flag_sdo_err & ~clear_errors);
			flag_frame_err <= frame_err_now | (flag_frame_err & ~clear_errors);
		end
	end

	// Command execution at frame end, including lock, unlock and standby
	always @(posedge clk) begin
		if (srst | power_on_reset_event) begin
			write_strobe    <= 1'b0;
			write_data      <= `BYTE_ZERO;
			standby_request <= 1'b0;
			write_locked    <= 1'b0;
		end else begin
			write_strobe    <= 1'b0;
			standby_request <= 1'b0;
			if (state == ST_EXEC && frame_valid) begin
				if (cmd_code == `CMD_WRITE_LOCK) begin
					if (data_byte == `DATA_LOCK) begin
						write_locked <= 1'b1;
					end
				end else if (cmd_code == `CMD_WRITE_UNLOCK) begin
					if (data_byte == `DATA_UNLOCK) begin
						write_locked <= 1'b0;
					end
				end else if (cmd_code == `CMD_STANDBY) begin
					standby_request <= (data_byte == `DATA_STANDBY);
				end else if (cmd_was_write && write_allowed) begin
					write_strobe <= 1'b1;
					write_data   <= data_byte;
				end
			end
		end
	end

	// Self-test completion: request re-initialisation, then refresh the state code
	always @(posedge clk) begin
		if (srst | power_on_reset_event) begin
			reinit_strobe      <= 1'b0;
			state_code_refresh <= 1'b0;
		end else begin
			reinit_strobe      <= self_test_done;
			state_code_refresh <= reinit_strobe;
		end
	end

endmodule // spi_status_lock

`default_nettype wire

// *** test/spi_status_lock_properties.sv ***
// Checker for the serial status and write-lock front end.
// Assumes binding to spi_status_lock; it sees that module's ports only.
`timescale 1ns/1ns
`default_nettype none
module spi_status_lock_properties (
	// Clock, reset and events
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       power_on_reset_event,
	input wire logic       self_test_done,
	input wire logic       diag_state,
	// Serial side
	input wire logic       chip_select_n,
	input wire logic       serial_data_out,
	input wire logic       serial_data_oe,
	// Register side
	input wire logic       cmd_lock_protected,
	input wire logic [6:0] cmd_code,
	input wire logic       write_strobe,
	input wire logic       standby_request,
	input wire logic       reinit_strobe,
	input wire logic       state_code_refresh,
	input wire logic       write_locked
);
	// Power-on events reset all but the pin synchroniser, so they gate the checks like srst
	default clocking @(posedge clk); endclocking
	default disable iff (srst || power_on_reset_event);
	// Six cycles cover the pin synchroniser and the output flop
	oe_idle_a: assert property (chip_select_n [*6] |-> !serial_data_oe) else $error("oe while deselected");
	released_high_a: assert property (!serial_data_oe |-> serial_data_out) else $error("released low");
	reinit_follow_a: assert property (self_test_done |=> reinit_strobe) else $error("no reinit");
	refresh_follow_a: assert property (reinit_strobe |=> state_code_refresh) else $error("no refresh");
	config_gate_a: assert property (write_strobe && (cmd_code == 7'h5b || cmd_code == 7'h4a)
		|-> diag_state && !write_locked) else $error("config write let through");
	lock_gate_a: assert property (write_strobe && cmd_lock_protected |-> !write_locked)
		else $error("locked write let through");
	special_write_a: assert property (write_strobe |-> !(cmd_code inside {7'h5e, 7'h5d, 7'h3e}))
		else $error("special command wrote");
	standby_code_a: assert property (standby_request |-> cmd_code == 7'h3e) else $error("stray standby");
	lock_set_a: assert property ($rose(write_locked) |-> cmd_code == 7'h5e) else $error("stray lock");
	lock_clear_a: assert property ($fell(write_locked) |-> cmd_code == 7'h5d || $past(power_on_reset_event))
		else $error("stray unlock");
	// Main scenarios
	cover property (write_strobe);
	cover property ($rose(write_locked));
	cover property (standby_request);
endmodule // spi_status_lock_properties
bind spi_status_lock spi_status_lock_properties chk (.*);
`default_nettype wire

// *** test/spi_master_model.sv ***
// Master stand-in on the serial pins: frames of up to 16 bits at a 125 ns clock.
// Assumes a pull-up on the data wire, so a released output reads back high.
`timescale 1ns/1ns
`default_nettype none
module spi_master_model (
	// Pins driven by the master
	output logic      chip_select_n,
	output logic      serial_clock_pin,
	output logic      serial_data_in,
	// Data wire seen from both ends
	input wire logic  serial_data_out,
	input wire logic  serial_data_oe,
	output wire logic serial_data_readback
);
	// Fault hook: pulls the data wire low to mimic a broken output path
	logic stuck_low;
	initial begin
		stuck_low = 1'b0;
		chip_select_n = 1'b1;
		serial_clock_pin = 1'b0;
		serial_data_in = 1'b0;
	end
	// Wire level: driver when enabled, pull-up otherwise
	assign serial_data_readback = stuck_low ? 1'b0 : (serial_data_oe ? serial_data_out : 1'b1);
	// One frame; nb below 16 cuts it short as a master reset would
	task automatic frame(input logic [15:0] tx, input int nb, output logic [15:0] rx);
		rx = 16'h0000;
		chip_select_n = 1'b0;
		#400;
		for (int i = 15; i > 15 - nb; i--) begin
			serial_clock_pin = 1'b1;
			serial_data_in = tx[i];
			#62;
			serial_clock_pin = 1'b0;
			rx[i] = serial_data_readback;
			#63;
		end
		// Idle data flips so a stale level is never mistaken for a bit
		serial_data_in = ~serial_data_in;
		#200;
		chip_select_n = 1'b1;
		#800;
	endtask
	// Clock fall while deselected, as traffic to another slave gives
	task automatic stray;
		serial_clock_pin = 1'b1;
		#100;
		serial_clock_pin = 1'b0;
		#300;
	endtask
endmodule // spi_master_model
`default_nettype wire

// *** test/spi_status_lock_tb.sv ***
// Testbench for the serial status and write-lock front end.
// Assumes spi_master_model on the pins; a small decoder stand-in answers cmd_code.
`timescale 1ns/1ns
`default_nettype none
module spi_status_lock_tb;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        diag_state = 1'b0;
	logic        self_test_done = 1'b0;
	logic        power_on_reset_event = 1'b0;
	logic        cmd_is_write = 1'b0;
	logic        cmd_undefined = 1'b0;
	logic        cmd_lock_protected = 1'b0;
	logic  [7:0] read_data = 8'h00;
	logic [15:0] rx;
	wire         chip_select_n, serial_clock_pin, serial_data_in, serial_data_readback;
	wire         serial_data_out, serial_data_oe, read_strobe, write_strobe, standby_request;
	wire         reinit_strobe, state_code_refresh, write_locked;
	wire   [6:0] cmd_code;
	wire   [7:0] write_data;
	int          errors = 0, n_tests = 0, n_wr = 0, n_sb = 0, n_rd = 0, cycles = 0, base;
	spi_status_lock dut (.*);
	spi_master_model master (.*);
	initial forever #4 clk = ~clk;
	// Decoder stand-in; answers settle half a cycle after cmd_code moves
	always @(negedge clk) begin
		cmd_is_write <= cmd_code inside {7'h5e, 7'h5d, 7'h5b, 7'h4a, 7'h3e, 7'h49, 7'h4f};
		cmd_undefined <= cmd_code == 7'h7f;
		cmd_lock_protected <= cmd_code inside {7'h5b, 7'h4a, 7'h4f};
		read_data <= {1'b0, cmd_code};
	end
	// Pulse counters and the hang limit
	always @(posedge clk) begin
		cycles++;
		if (write_strobe) n_wr++;
		if (read_strobe) n_rd++;
		if (standby_request) n_sb++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end
	// Command byte carries even parity
	function automatic logic [15:0] word(input logic [6:0] c, input logic [7:0] d);
		return {c, ^c, d};
	endfunction
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic send(input logic [15:0] tx, input int nb = 16);
		master.frame(tx, nb, rx);
	endtask
	// Read frame; its status byte reports the frame before it
	task automatic status(input logic [7:0] exp);
		send(word(7'h03, 8'h00));
		check("status", exp, rx[15:8]);
	endtask
	task automatic t_flags;
		base = n_rd;
		status(8'ha0);
		check("data", 16'h0003, rx[7:0]);
		send(word(7'h49, 8'h5a));
		check("write data", 16'h005a, write_data);
		status(8'ha8);
		send({7'h03, 1'b1, 8'h00});
		status(8'ha1);
		send(word(7'h7f, 8'h00));
		status(8'ha1);
		send(word(7'h03, 8'h00), 8);
		status(8'ha1);
		status(8'ha0);
		check("read strobes", base + 10, n_rd);
	endtask
	task automatic t_lock;
		base = n_wr;
		send(word(7'h5e, 8'haa));
		check("locked", 16'h0001, write_locked);
		send(word(7'h4f, 8'h11));
		send(word(7'h5d, 8'h54));
		check("still locked", 16'h0001, write_locked);
		send(word(7'h3e, 8'h01));
		send(word(7'h3e, 8'h00));
		check("standby", 16'h0001, n_sb);
		@(negedge clk) diag_state = 1'b1;
		send(word(7'h5b, 8'h01));
		send(word(7'h5d, 8'h55));
		check("unlocked", 16'h0000, write_locked);
		send(word(7'h4f, 8'h22));
		send(word(7'h4a, 8'h02));
		@(negedge clk) diag_state = 1'b0;
		send(word(7'h5b, 8'h03));
		check("writes", base + 2, n_wr);
	endtask
	// Stray fall shows up one frame late and never blocks the command
	task automatic t_out_error;
		base = n_wr;
		master.stray();
		send(word(7'h49, 8'h66));
		check("executed", base + 1, n_wr);
		status(8'hac);
		status(8'ha0);
		// Readback mismatch inside a frame: flagged, yet the write still lands
		master.stuck_low = 1'b1;
		send(word(7'h49, 8'h77));
		master.stuck_low = 1'b0;
		check("executed on error", base + 2, n_wr);
		status(8'hac);
		status(8'ha0);
	endtask
	task automatic t_events;
		@(negedge clk) self_test_done = 1'b1;
		@(negedge clk) self_test_done = 1'b0;
		send(word(7'h5e, 8'haa));
		@(negedge clk) power_on_reset_event = 1'b1;
		@(negedge clk) power_on_reset_event = 1'b0;
		repeat (4) @(negedge clk);
		check("lock after event", 16'h0000, write_locked);
		status(8'ha0);
	endtask
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		t_flags();
		t_lock();
		t_out_error();
		t_events();
		wrap_up();
	end
endmodule // spi_status_lock_tb
`default_nettype wire
